/* rtl/hbu_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module hbu_fifo #(
  parameter int unsigned WIDTH = 28,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  hbu_stream_if.snk push_if,
  hbu_stream_if.src pop_if
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("hbu_fifo: DEPTH must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_ff;
  logic [AW:0] rptr_ff;
  wire full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
  wire empty = (wptr_ff == rptr_ff);
  wire do_push = ce_i && push_if.valid && !full;
  wire do_pop = ce_i && pop_if.ready && !empty;
  assign push_if.ready = !full;
  assign pop_if.valid = !empty;
  assign pop_if.data = mem[rptr_ff[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wptr_ff[AW-1:0]] <= push_if.data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      if (do_push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (do_pop) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
    end
  end
endmodule : hbu_fifo

/* rtl/hbu_pkg.sv */
// Constants shared by the host bus unit and its write queue
package hbu_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BUS_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BE_W = 4;
  localparam int unsigned ENTRY_W = ADDR_W + BE_W + BUS_W;
  localparam int unsigned FIFO_DEPTH = 32;
  // Pin synchroniser: strobes and command in the low bits, lanes above
  localparam int unsigned PIN_W = BUS_W + 5;
  localparam int unsigned PIN_CS = 0;
  localparam int unsigned PIN_RD = 1;
  localparam int unsigned PIN_WR = 2;
  localparam int unsigned PIN_CMD = 3;
  localparam int unsigned PIN_STRAP = 4;
  localparam int unsigned PIN_LANE0 = 5;
  localparam logic [PIN_W-1:0] PIN_RST = 21'h000007;
  // Receive data pointer configuration bits
  localparam int unsigned CFG_ENDIAN_BIT = 11;
  localparam int unsigned CFG_WR_PULSE_BIT = 12;
  // Command phase field layout in 16-bit mode
  localparam int unsigned CMD_ADDR_HI = 7;
  localparam int unsigned CMD_ADDR_LO = 2;
  localparam int unsigned CMD_BE_HI = 15;
  localparam int unsigned CMD_BE_LO = 12;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic [BE_W-1:0] BE_RST = 4'h0;
  // Internal write pulse: least delay after the strobe falls
  localparam int unsigned WR_PULSE_NS = 50;
  localparam int unsigned WR_PULSE_CYC =
    (WR_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000 < 1 ? 1 :
    (WR_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned STRAP_SAMPLE_CYC = 3;
  typedef enum logic [3:0] {
    WS_IDLE = 4'b0001,
    WS_DELAY = 4'b0010,
    WS_RISE = 4'b0100,
    WS_PUSH = 4'b1000
  } wr_state_t;
endpackage : hbu_pkg

/* rtl/hbu_stream_if.sv */
// Valid/ready word stream between the bus unit and its queue
`timescale 1ns/1ps
interface hbu_stream_if #(
  parameter int unsigned WIDTH = 28
);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : hbu_stream_if

/* rtl/host_bus_unit.sv */
// Shared-bus host interface unit: command and data phases over one bus
// Summary of operation
// - 16-bit mode takes bytes and words; 8-bit bytes
// - Byte swapping done inside; lanes wired straight
// - Command low: data over all sixteen lanes in 16-bit mode, lanes 7:0 in 8-bit
// - 16-bit command write loads address and enables
// - Accesses accepted only with chip select low
// - Interrupt output low when interrupt pending
// - Write data caught by internal timed pulse
// - Endian strap: low little, high big
// - Strap low: config bit 11 picks endianness
// - Command read returns latched address, plus enables in 16-bit mode
// - Single and burst transfers, no address latch
`timescale 1ns/1ps
module host_bus_unit
  import hbu_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  input wire logic BUS16_I,
  input wire logic ENDIAN_STRAP_I,
  input wire logic CMD_I,
  input wire logic CHIP_SELECT_N_I,
  input wire logic READ_STROBE_N_I,
  input wire logic WRITE_STROBE_N_I,
  input wire logic [BUS_W-1:0] SHARED_BUS_I,
  output logic [BUS_W-1:0] SHARED_BUS_O,
  output logic SHARED_BUS_OE_O,
  input wire logic IRQ_I,
  output logic IRQ_OUT_N_O,
  input wire logic [BUS_W-1:0] RX_DATA_POINTER_CFG_I,
  output logic BIG_ENDIAN_O,
  output logic [ADDR_W-1:0] CMD_ADDR_O,
  output logic [BE_W-1:0] CMD_BE_O,
  output logic WR_VALID_O,
  input wire logic WR_READY_I,
  output logic [ADDR_W-1:0] WR_ADDR_O,
  output logic [BE_W-1:0] WR_BE_O,
  output logic [BUS_W-1:0] WR_DATA_O,
  output logic OVERRUN_O,
  output logic RD_REQ_O,
  input wire logic [BUS_W-1:0] RD_DATA_I
);
  if (DEPTH < 2) begin : g_chk
    $error("host_bus_unit: DEPTH must be at least 2");
  end

  function automatic logic [BUS_W-1:0] swap16(input logic [BUS_W-1:0] d, input logic sw);
    swap16 = sw ? {d[7:0], d[15:8]} : d;
  endfunction : swap16

  function automatic logic [BE_W-1:0] byte_be(input logic [1:0] a);
    byte_be = BE_W'(4'h1 << a);
  endfunction : byte_be

  logic [PIN_W-1:0] s1_ff, s2_ff, s3_ff, pin_ff, pin_prev_ff;
  logic big_strap_ff;
  logic [2:0] strap_cnt_ff;
  wr_state_t wst_ff, nxt_wst;
  logic [2:0] dly_ff;
  logic cmd_at_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [BE_W-1:0] be_ff;
  logic [ENTRY_W-1:0] entry_ff;
  logic rd_pend_ff;
  logic rd_req_ff;
  logic [BUS_W-1:0] bus_out_ff;
  logic oe_ff;
  logic irq_n_ff;
  logic ovr_ff;

  wire [PIN_W-1:0] pins = {SHARED_BUS_I, ENDIAN_STRAP_I, CMD_I, WRITE_STROBE_N_I,
                           READ_STROBE_N_I, CHIP_SELECT_N_I};
  // Only bits whose last two stages agree move on
  wire [PIN_W-1:0] nxt_pin = (s2_ff & s3_ff) | (pin_ff & (s2_ff ^ s3_ff));
  wire [BUS_W-1:0] lanes = pin_ff[PIN_LANE0 +: BUS_W];
  wire cs_act = !pin_ff[PIN_CS];
  wire cmd_lvl = pin_ff[PIN_CMD];
  wire wr_fall = !pin_ff[PIN_WR] && pin_prev_ff[PIN_WR];
  wire wr_rise = pin_ff[PIN_WR] && !pin_prev_ff[PIN_WR];
  wire rd_fall = !pin_ff[PIN_RD] && pin_prev_ff[PIN_RD];
  wire rd_act = !pin_ff[PIN_RD];
  wire pulse_cfg = RX_DATA_POINTER_CFG_I[CFG_WR_PULSE_BIT];
  // Pulled-up strap forces big endian; otherwise the config bit decides
  wire big = big_strap_ff | RX_DATA_POINTER_CFG_I[CFG_ENDIAN_BIT];
  wire wr_start = (wst_ff == WS_IDLE) && wr_fall && cs_act;
  wire dly_done = (wst_ff == WS_DELAY) && (dly_ff == 3'h0);
  wire capture = dly_done || ((wst_ff == WS_RISE) && wr_rise);
  wire [ADDR_W-1:0] cmd_addr16 = {lanes[CMD_ADDR_HI:CMD_ADDR_LO], 2'b00};
  wire [BE_W-1:0] cmd_be16 = lanes[CMD_BE_HI:CMD_BE_LO];
  wire [ADDR_W-1:0] cmd_addr8 = lanes[ADDR_W-1:0];
  wire [1:0] lane_sel8 = {addr_ff[1], addr_ff[0] ^ big};
  // 8-bit mode takes a single byte; 16-bit mode the latched enables
  wire [BE_W-1:0] data_be = BUS16_I ? be_ff : byte_be(lane_sel8);
  wire [BUS_W-1:0] data_wr = BUS16_I ? swap16(lanes, big) :
                             {lanes[7:0], lanes[7:0]};
  wire [BUS_W-1:0] cmd_read = BUS16_I ? {be_ff, 4'h0, addr_ff[7:2], 2'b00} :
                              {8'h00, addr_ff};
  wire [BUS_W-1:0] data_read = BUS16_I ? swap16(RD_DATA_I, big) :
                               {8'h00, lane_sel8[0] ? RD_DATA_I[15:8] : RD_DATA_I[7:0]};
  wire push_ready;

  hbu_stream_if #(.WIDTH(ENTRY_W)) push_s ();
  hbu_stream_if #(.WIDTH(ENTRY_W)) pop_s ();

  assign push_s.data = entry_ff;
  assign push_s.valid = (wst_ff == WS_PUSH);
  assign push_ready = push_s.ready;
  assign pop_s.ready = WR_READY_I;
  assign WR_VALID_O = pop_s.valid;
  assign {WR_ADDR_O, WR_BE_O, WR_DATA_O} = pop_s.data;

  hbu_fifo #(.WIDTH(ENTRY_W), .DEPTH(DEPTH)) u_queue (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .ce_i(CE_I),
    .push_if(push_s),
    .pop_if(pop_s)
  );

  always_comb begin
    nxt_wst = wst_ff;
    unique case (wst_ff)
      WS_IDLE: begin
        if (wr_start) begin
          nxt_wst = pulse_cfg ? WS_DELAY : WS_RISE;
        end
      end
      WS_DELAY, WS_RISE: begin
        if (capture) begin
          nxt_wst = cmd_at_ff ? WS_IDLE : WS_PUSH;
        end
      end
      WS_PUSH: begin
        // A full queue holds the entry here; the next write is lost
        if (push_ready) begin
          nxt_wst = WS_IDLE;
        end
      end
      default: nxt_wst = WS_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s1_ff <= PIN_RST;
      s2_ff <= PIN_RST;
      s3_ff <= PIN_RST;
      pin_ff <= PIN_RST;
      pin_prev_ff <= PIN_RST;
    end else if (CE_I) begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= nxt_pin;
      pin_prev_ff <= pin_ff;
    end
  end

  // Strap is caught once; stages refill from reset first, so the last sample counts
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      strap_cnt_ff <= 3'h0;
      big_strap_ff <= 1'b0;
    end else if (CE_I && strap_cnt_ff != 3'(STRAP_SAMPLE_CYC + 1)) begin
      strap_cnt_ff <= strap_cnt_ff + 3'h1;
      big_strap_ff <= nxt_pin[PIN_STRAP];
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wst_ff <= WS_IDLE;
      dly_ff <= 3'h0;
      cmd_at_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else if (CE_I) begin
      wst_ff <= nxt_wst;
      ovr_ff <= (wst_ff == WS_PUSH) && !push_ready && wr_fall && cs_act;
      if (wr_start) begin
        cmd_at_ff <= cmd_lvl;
        dly_ff <= 3'(WR_PULSE_CYC - 1);
      end else if (wst_ff == WS_DELAY) begin
        dly_ff <= dly_ff - 3'h1;
      end
    end
  end

  // Address stays until the next command write, so bursts need no latch
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      addr_ff <= ADDR_RST;
      be_ff <= BE_RST;
      entry_ff <= '0;
    end else if (CE_I && capture) begin
      if (cmd_at_ff) begin
        addr_ff <= BUS16_I ? cmd_addr16 : cmd_addr8;
        be_ff <= BUS16_I ? cmd_be16 : byte_be(cmd_addr8[1:0]);
      end else begin
        entry_ff <= {addr_ff, data_be, data_wr};
      end
    end
  end

  // Read data is formed one cycle after the request, then held
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_pend_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      bus_out_ff <= '0;
      oe_ff <= 1'b0;
      irq_n_ff <= 1'b1;
    end else if (CE_I) begin
      irq_n_ff <= !IRQ_I;
      oe_ff <= cs_act && rd_act;
      rd_req_ff <= rd_fall && cs_act && !cmd_lvl;
      rd_pend_ff <= rd_req_ff;
      if (rd_fall && cs_act && cmd_lvl) begin
        bus_out_ff <= cmd_read;
      end else if (rd_req_ff) begin
        bus_out_ff <= data_read;
      end
    end
  end

  assign RD_REQ_O = rd_req_ff;
  assign SHARED_BUS_O = bus_out_ff;
  assign SHARED_BUS_OE_O = oe_ff;
  assign IRQ_OUT_N_O = irq_n_ff;
  assign BIG_ENDIAN_O = big;
  assign CMD_ADDR_O = addr_ff;
  assign CMD_BE_O = be_ff;
  assign OVERRUN_O = ovr_ff;
endmodule : host_bus_unit

/* tb/hbu_checker.sv */
// Port-level assertions for the host bus unit
`timescale 1ns/1ps
module hbu_checker
  import hbu_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  input wire logic BUS16_I,
  input wire logic CMD_I,
  input wire logic CHIP_SELECT_N_I,
  input wire logic IRQ_I,
  input wire logic IRQ_OUT_N_O,
  input wire logic [BUS_W-1:0] RX_DATA_POINTER_CFG_I,
  input wire logic BIG_ENDIAN_O,
  input wire logic SHARED_BUS_OE_O,
  input wire logic [ADDR_W-1:0] CMD_ADDR_O,
  input wire logic [BE_W-1:0] CMD_BE_O,
  input wire logic RD_REQ_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Pins lag about four edges, so eight quiet cycles settle them
  sequence cs_quiet;
    (CHIP_SELECT_N_I && CE_I)[*8];
  endsequence
  sequence data_only;
    (!CMD_I && CE_I)[*8];
  endsequence
  a_cs_gates:
    assert property (cs_quiet |-> !RD_REQ_O && $stable(CMD_ADDR_O)) else $error("cs ignored");
  a_addr_kept:
    assert property (data_only |-> $stable(CMD_ADDR_O) && $stable(CMD_BE_O))
    else $error("address lost");
  a_irq_low:
    assert property (CE_I && IRQ_I |=> !IRQ_OUT_N_O) else $error("irq not driven");
  a_cfg_endian:
    assert property (RX_DATA_POINTER_CFG_I[CFG_ENDIAN_BIT] |-> BIG_ENDIAN_O)
    else $error("endian bit ignored");
  a_read_drives:
    assert property (RD_REQ_O |-> SHARED_BUS_OE_O ##1 SHARED_BUS_OE_O) else $error("no drive");
  a_req_pulse:
    assert property (RD_REQ_O |=> !RD_REQ_O) else $error("request too long");
  a_be_onehot:
    assert property (!BUS16_I && $changed(CMD_ADDR_O) |-> CMD_BE_O == 4'h1 << CMD_ADDR_O[1:0])
    else $error("byte enable wrong");
  a_addr_aligned:
    assert property (BUS16_I && $changed(CMD_ADDR_O) |-> CMD_ADDR_O[1:0] == 2'h0)
    else $error("address not aligned");
endmodule : hbu_checker

bind host_bus_unit hbu_checker i_hbu_checker (.REF_CLK_I, .RESET_N_I, .CE_I, .BUS16_I, .CMD_I,
  .CHIP_SELECT_N_I, .IRQ_I, .IRQ_OUT_N_O, .RX_DATA_POINTER_CFG_I, .BIG_ENDIAN_O,
  .SHARED_BUS_OE_O, .CMD_ADDR_O, .CMD_BE_O, .RD_REQ_O);

/* tb/hbu_host_model.sv */
// Behavioural host processor on the shared bus
`timescale 1ns/1ps
module hbu_host_model
  import hbu_pkg::*;
(
  input wire logic clk_i,
  input wire logic bus16_i,
  input wire logic [BUS_W-1:0] bus_i,
  output logic [BUS_W-1:0] bus_o,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic cmd_o
);
  initial begin
    bus_o = '0;
    cs_n_o = 1'h0;
    rd_n_o = 1'h1;
    wr_n_o = 1'h1;
    cmd_o = 1'h0;
  end
  // Strobe held nine cycles, past the six cycle answer time
  task automatic access(input logic cs_n, input logic c, input logic w,
                        input logic [BUS_W-1:0] d, output logic [BUS_W-1:0] q);
    @(posedge clk_i);
    cs_n_o <= cs_n;
    cmd_o <= c;
    bus_o <= bus16_i ? d : {8'h00, d[7:0]};
    rd_n_o <= w;
    wr_n_o <= !w;
    repeat (9) @(posedge clk_i);
    q = bus_i;
    rd_n_o <= 1'h1;
    wr_n_o <= 1'h1;
    cs_n_o <= 1'h0;
    // Lanes held past the strobe rise, where a plain write lands
    repeat (4) @(posedge clk_i);
    // Released lanes show garbage, never the old value
    bus_o <= bus16_i ? ~d : {8'h00, ~d[7:0]};
    repeat (2) @(posedge clk_i);
  endtask : access
endmodule : hbu_host_model

/* tb/tb_host_bus_unit.sv */
// Self-checking bench for the host bus unit
`timescale 1ns/1ps
module tb_host_bus_unit import hbu_pkg::*;;
  typedef logic [ENTRY_W-1:0] w_t;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic b16 = 1'h1;
  logic strap = 1'h0;
  logic irq = 1'h0;
  logic rdy = 1'h0;
  logic hold = 1'h0;
  logic [BUS_W-1:0] cfg = '0;
  logic [BUS_W-1:0] rdd = '0;
  logic [BUS_W-1:0] bus_w, hbus, sbo, wd, q;
  logic cs_n, rd_n, wr_n, cmd, oe, irq_n, big, wv, ovr, rq;
  logic [ADDR_W-1:0] ca, wa;
  logic [BE_W-1:0] cb, wb;
  w_t exp_q[$];
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_ovr = 0;
  always #12.5 clk = ~clk;
  assign bus_w = oe ? sbo : hbus;
  host_bus_unit i_host_bus_unit (.REF_CLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'h1), .BUS16_I(b16),
    .ENDIAN_STRAP_I(strap), .CMD_I(cmd), .CHIP_SELECT_N_I(cs_n), .READ_STROBE_N_I(rd_n),
    .WRITE_STROBE_N_I(wr_n), .SHARED_BUS_I(bus_w), .SHARED_BUS_O(sbo), .SHARED_BUS_OE_O(oe),
    .IRQ_I(irq), .IRQ_OUT_N_O(irq_n), .RX_DATA_POINTER_CFG_I(cfg), .BIG_ENDIAN_O(big),
    .CMD_ADDR_O(ca), .CMD_BE_O(cb), .WR_VALID_O(wv), .WR_READY_I(rdy), .WR_ADDR_O(wa),
    .WR_BE_O(wb), .WR_DATA_O(wd), .OVERRUN_O(ovr), .RD_REQ_O(rq), .RD_DATA_I(rdd));
  hbu_host_model i_hbu_host_model (.clk_i(clk), .bus16_i(b16), .bus_i(bus_w), .bus_o(hbus),
    .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .cmd_o(cmd));
  task automatic check(input w_t got, input w_t exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  function automatic logic [BUS_W-1:0] sw(input logic [BUS_W-1:0] d, input logic b);
    return b ? {d[7:0], d[15:8]} : d;
  endfunction : sw
  task automatic wr(input logic c, input logic [BUS_W-1:0] d);
    i_hbu_host_model.access(1'h0, c, 1'h1, d, q);
  endtask : wr
  task automatic rd(input logic c, input logic [BUS_W-1:0] e);
    i_hbu_host_model.access(1'h0, c, 1'h0, ~e, q);
    check(w_t'(q), w_t'(e));
  endtask : rd
  // Consumer stalls at random unless the fill test holds it off
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rdy <= !hold && $urandom_range(1);
    if (ovr) n_ovr <= n_ovr + 1;
    if (rst_n && wv && rdy) check({wa, wb, wd}, exp_q.size() ? exp_q.pop_front() : ~{wa, wb, wd});
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    logic [BUS_W-1:0] d;
    logic [BUS_W-1:0] c16;
    logic [7:0] a;
    void'($urandom(54));
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
    c16 = 16'($urandom) | 16'h0002;
    wr(1'h1, c16);
    check(w_t'({ca, cb}), w_t'({c16[7:2], 2'h0, c16[15:12]}));
    rd(1'h1, {c16[15:12], 4'h0, c16[7:2], 2'h0});
    i_hbu_host_model.access(1'h1, 1'h1, 1'h1, ~c16, q);
    check(w_t'({ca, cb}), w_t'({c16[7:2], 2'h0, c16[15:12]}));
    // Second pass is big endian with the timed write pulse
    for (int e = 0; e < 2; e++) begin
      cfg <= {3'h0, e[0], e[0], 11'h000};
      repeat (3) begin
        d = 16'($urandom);
        exp_q.push_back({c16[7:2], 2'h0, c16[15:12], sw(d, e[0])});
        wr(1'h0, d);
      end
      check(w_t'(big), w_t'(e));
      rdd <= 16'($urandom);
      @(posedge clk);
      rd(1'h0, sw(rdd, e[0]));
    end
    cfg <= '0;
    for (int i = 0; i < 2; i++) begin
      irq <= !i[0];
      repeat (3) @(posedge clk);
      check(w_t'(irq_n), w_t'(i));
    end
    b16 <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      a = {6'($urandom), i[1:0]};
      wr(1'h1, {8'h00, a});
      check(w_t'({ca, cb}), w_t'({a, 4'h1 << i[1:0]}));
      rd(1'h1, {8'h00, a});
      d = 16'($urandom);
      exp_q.push_back({a, 4'h1 << i[1:0], d[7:0], d[7:0]});
      wr(1'h0, {8'h00, d[7:0]});
      rd(1'h0, {8'h00, i[0] ? rdd[15:8] : rdd[7:0]});
    end
    b16 <= 1'h1;
    hold <= 1'h1;
    repeat (FIFO_DEPTH + 2) begin
      d = 16'($urandom);
      if (exp_q.size() <= FIFO_DEPTH) exp_q.push_back({a, 4'h8, d});
      wr(1'h0, d);
    end
    check(w_t'(n_ovr), w_t'(1));
    hold <= 1'h0;
    for (int t = 0; t < 400 && exp_q.size() > 0; t++) @(posedge clk);
    check(w_t'(exp_q.size()), w_t'(0));
    strap <= 1'h1;
    rst_n <= 1'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
    check(w_t'({big, ca}), w_t'({1'h1, 8'h00}));
    summarize();
  end
endmodule : tb_host_bus_unit
